// [rtl/rssd_datapath.sv]
// accumulator datapath slice: rotate, subtract with borrow, decrement-skip
`default_nettype none
module rssd_datapath
  import rssd_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic START_IN,
  input wire logic [1:0] OP_IN,
  input wire logic [7:0] MEM_RD_IN,
  output logic [7:0] ACC_OUT,
  output logic C_OUT,
  output logic Z_OUT,
  output logic OV_OUT,
  output logic AC_OUT,
  output logic MEM_WE_OUT,
  output logic [7:0] MEM_WD_OUT,
  output logic SKIP_OUT,
  output logic DONE_OUT
);
  // ----------------------------------------
  // operation decoding
  // ----------------------------------------
  function automatic logic op_is_rot(input logic [1:0] op);
    return op == OP_ROT;
  endfunction

  function automatic logic op_is_sub(input logic [1:0] op);
    return op == OP_SUB_ACC || op == OP_SUB_MEM;
  endfunction

  function automatic logic op_is_dec(input logic [1:0] op);
    return op == OP_DEC_SKIP;
  endfunction

  // the accumulator takes the rotate and the subtract-to-acc only
  function automatic logic op_writes_acc(input logic [1:0] op);
    return op == OP_ROT || op == OP_SUB_ACC;
  endfunction

  function automatic logic op_writes_mem(input logic [1:0] op);
    return op == OP_SUB_MEM || op == OP_DEC_SKIP;
  endfunction

  function automatic logic byte_is_zero(input byte_t b);
    return b == ZERO_BYTE;
  endfunction

  // ----------------------------------------
  // arithmetic
  // ----------------------------------------
  rssd_alu_if alu_bus ();
  byte_t acc_reg;
  logic c_reg;
  logic z_reg;
  logic ov_reg;
  logic ac_reg;
  logic mem_we_reg;
  byte_t mem_wd_reg;
  logic skip_reg;
  logic done_reg;

  assign alu_bus.op = OP_IN;
  assign alu_bus.acc = acc_reg;
  assign alu_bus.mem = MEM_RD_IN;
  assign alu_bus.carry = c_reg;

  rssd_alu u_alu (
    .bus(alu_bus)
  );

  // ----------------------------------------
  // strobes
  // ----------------------------------------
  // every strobe needs START_IN: an idle cycle leaves the accumulator and flags alone, though the write data still loads
  logic go_rot;
  logic go_sub;
  logic go_dec;
  logic go_acc_wr;
  logic go_mem_wr;
  logic go_carry;

  assign go_rot = START_IN && op_is_rot(OP_IN);
  assign go_sub = START_IN && op_is_sub(OP_IN);
  assign go_dec = START_IN && op_is_dec(OP_IN);
  assign go_acc_wr = START_IN && op_writes_acc(OP_IN);
  assign go_mem_wr = START_IN && op_writes_mem(OP_IN);
  // decrement-skip is the only operation that leaves carry alone
  assign go_carry = go_rot || go_sub;

  // ----------------------------------------
  // next-state values
  // ----------------------------------------
  byte_t acc_next;
  logic c_next;
  logic z_next;
  logic ov_next;
  logic ac_next;
  logic mem_we_next;
  byte_t mem_wd_next;
  logic skip_next;
  logic done_next;

  always_comb
  begin
    acc_next = acc_reg;
    c_next = c_reg;
    z_next = z_reg;
    ov_next = ov_reg;
    ac_next = ac_reg;
    if (go_acc_wr)
      acc_next = alu_bus.result;
    if (go_carry)
      c_next = alu_bus.c_out;
    // decrement-skip never reaches these: flags hold
    if (go_sub)
    begin
      z_next = alu_bus.z_out;
      ov_next = alu_bus.ov_out;
      ac_next = alu_bus.ac_out;
    end
    // strobe and data leave together; the rotate never writes memory
    mem_we_next = go_mem_wr;
    mem_wd_next = alu_bus.result;
    // a wrapped ff from zero is not zero, so it never skips
    skip_next = go_dec && byte_is_zero(alu_bus.result);
    done_next = START_IN;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      acc_reg <= ACC_RESET;
    end
    else
    begin
      acc_reg <= acc_next;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      c_reg <= FLAG_RESET;
    end
    else
    begin
      c_reg <= c_next;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      z_reg <= FLAG_RESET;
    end
    else
    begin
      z_reg <= z_next;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      ov_reg <= FLAG_RESET;
    end
    else
    begin
      ov_reg <= ov_next;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      ac_reg <= FLAG_RESET;
    end
    else
    begin
      ac_reg <= ac_next;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      mem_we_reg <= 1'b0;
    end
    else
    begin
      mem_we_reg <= mem_we_next;
    end
  end

  // data is loaded every cycle; only the strobe says it is meant
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      mem_wd_reg <= ZERO_BYTE;
    end
    else
    begin
      mem_wd_reg <= mem_wd_next;
    end
  end

  // skip pulse asks the sequencer for one dummy fetch cycle
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      skip_reg <= 1'b0;
    end
    else
    begin
      skip_reg <= skip_next;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= done_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output is a flop; the pulses drop one cycle after their start
  assign ACC_OUT = acc_reg;
  assign C_OUT = c_reg;
  assign Z_OUT = z_reg;
  assign OV_OUT = ov_reg;
  assign AC_OUT = ac_reg;
  assign MEM_WE_OUT = mem_we_reg;
  assign MEM_WD_OUT = mem_wd_reg;
  assign SKIP_OUT = skip_reg;
  assign DONE_OUT = done_reg;
endmodule
`default_nettype wire

// [rtl/rssd_pkg.sv]
// constants and types shared by the rotate/subtract/skip datapath
`default_nettype none
package rssd_pkg;
  localparam int DATA_W = 8;
  localparam int MSB = 7;
  localparam int NIB = 4;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [1:0] OP_ROT = 2'h0;
  localparam logic [1:0] OP_SUB_ACC = 2'h1;
  localparam logic [1:0] OP_SUB_MEM = 2'h2;
  localparam logic [1:0] OP_DEC_SKIP = 2'h3;
  typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// [rtl/rssd_alu_if.sv]
// carrier between the sequencer-facing top and the arithmetic unit
`default_nettype none
interface rssd_alu_if;
  import rssd_pkg::*;
  logic [1:0] op;
  byte_t acc;
  byte_t mem;
  logic carry;
  byte_t result;
  logic c_out;
  logic z_out;
  logic ov_out;
  logic ac_out;
  modport top (output op, acc, mem, carry,
               input result, c_out, z_out, ov_out, ac_out);
  modport alu (input op, acc, mem, carry,
               output result, c_out, z_out, ov_out, ac_out);
endinterface
`default_nettype wire

// [rtl/rssd_alu.sv]
// combinational arithmetic of the four operations
`default_nettype none
module rssd_alu
  import rssd_pkg::*;
(
  rssd_alu_if.alu bus
);
  logic [8:0] diff;
  logic [4:0] low;
  always_comb
  begin
    // 9-bit difference: bit 8 set means a borrow out
    diff = {1'b0, bus.acc} - {1'b0, bus.mem} - {8'h00, ~bus.carry};
    low = {1'b0, bus.acc[3:0]} - {1'b0, bus.mem[3:0]} - {4'h0, ~bus.carry};
    bus.result = diff[7:0];
    bus.c_out = bus.carry;
    bus.z_out = 1'b0;
    bus.ov_out = 1'b0;
    bus.ac_out = 1'b0;
    unique case (bus.op)
      OP_ROT:
      begin
        bus.result = {bus.carry, bus.mem[MSB:1]};
        bus.c_out = bus.mem[0];
      end
      OP_SUB_ACC, OP_SUB_MEM:
      begin
        bus.c_out = ~diff[8];
        bus.z_out = (diff[7:0] == ZERO_BYTE);
        bus.ac_out = ~low[NIB];
        bus.ov_out = (bus.acc[MSB] ^ bus.mem[MSB])
                     & (bus.acc[MSB] ^ diff[MSB]);
      end
      OP_DEC_SKIP:
      begin
        bus.result = bus.mem - ONE_BYTE;
      end
    endcase
  end
endmodule
`default_nettype wire

// [tb/rssd_mem_model.sv]
// data memory byte standing behind the slice
`default_nettype none
module rssd_mem_model (
  input wire logic clk_in,
  input wire logic ld_in,
  input wire logic [7:0] ld_val_in,
  input wire logic we_in,
  input wire logic [7:0] wd_in,
  output logic [7:0] rd_out
);
  timeunit 1ns / 1ps;
  // a bench load wins over a write-back in the same cycle
  always @(posedge clk_in)
    if (ld_in)
      rd_out <= ld_val_in;
    else if (we_in)
      rd_out <= wd_in;
endmodule
`default_nettype wire

// [tb/rssd_datapath_chk.sv]
// port checks of the datapath slice
`default_nettype none
module rssd_datapath_chk
  import rssd_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic START_IN,
  input wire logic [1:0] OP_IN,
  input wire logic [7:0] MEM_RD_IN,
  input wire logic [7:0] ACC_OUT,
  input wire logic C_OUT,
  input wire logic MEM_WE_OUT,
  input wire logic [7:0] MEM_WD_OUT,
  input wire logic SKIP_OUT
);
  timeunit 1ns / 1ps;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  logic [3:0] go;
  logic [8:0] dif;
  assign go = START_IN ? 4'h1 << OP_IN : 4'h0;
  // bit 8 is the borrow out
  assign dif = {1'b0, ACC_OUT} - {1'b0, MEM_RD_IN} - {8'h00, !C_OUT};
  a_rot_value: assert property (go[0] |=> C_OUT == $past(MEM_RD_IN[0]) &&
    ACC_OUT == {$past(C_OUT), $past(MEM_RD_IN[7:1])}) else $error("rot");
  a_rot_nowrite: assert property (go[0] |=> !MEM_WE_OUT)
    else $error("rot wr");
  a_sub_acc: assert property (go[1] |=> ACC_OUT == $past(dif[7:0]))
    else $error("sub acc");
  a_sub_mem: assert property (go[2] |=> MEM_WE_OUT &&
    MEM_WD_OUT == $past(dif[7:0])) else $error("sub mem");
  a_sub_carry: assert property (go[1] || go[2] |=> C_OUT == !$past(dif[8]))
    else $error("borrow");
  a_dec_write: assert property (go[3] |=> MEM_WE_OUT &&
    MEM_WD_OUT == $past(MEM_RD_IN) - 8'h01) else $error("dec");
  a_skip_zero: assert property (go[3] && MEM_RD_IN == 8'h01 |=> SKIP_OUT)
    else $error("skip");
  a_skip_not: assert property (go[3] && MEM_RD_IN != 8'h01 |=> !SKIP_OUT)
    else $error("noskip");
  cover property (SKIP_OUT);
  cover property (go[2]);
  cover property (go[0]);
endmodule
bind rssd_datapath rssd_datapath_chk rssd_datapath_chk_i (.*);
`default_nettype wire

// [tb/tb.sv]
// self-checking bench of the datapath slice
`default_nettype none
module tb;
  import rssd_pkg::*;
  timeunit 1ns / 1ps;
  logic clk = 1'b0, rst = 1'b1, st = 1'b0, ld = 1'b0, we, sk, skd, dnd;
  logic [1:0] op = 2'h0;
  logic [7:0] ldv = 8'h00, rd, acc, wd;
  logic c, z, ov, ac, done;
  int fail_count = 0, compares = 0;
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
  always #2.5 clk = ~clk;
  rssd_datapath rssd_datapath_i (.CLK_IN(clk), .RST_IN(rst), .START_IN(st),
    .OP_IN(op), .MEM_RD_IN(rd), .ACC_OUT(acc), .C_OUT(c), .Z_OUT(z),
    .OV_OUT(ov), .AC_OUT(ac), .MEM_WE_OUT(we), .MEM_WD_OUT(wd),
    .SKIP_OUT(sk), .DONE_OUT(done));
  rssd_mem_model rssd_mem_model_i (.clk_in(clk), .ld_in(ld), .ld_val_in(ldv),
    .we_in(we), .wd_in(wd), .rd_out(rd));
  task run(input logic [1:0] o, input logic [7:0] m);
    @(posedge clk);
    ld <= 1'b1;
    ldv <= m;
    @(posedge clk);
    ld <= 1'b0;
    st <= 1'b1;
    op <= o;
    @(posedge clk);
    st <= 1'b0;
    #1 skd = sk;
    dnd = done;
    @(posedge clk);
    #1;
  endtask
  task t_rot;
    run(OP_ROT, 8'h81);
    `CHK("acc", 8'h40, acc)
    `CHK("carry", 1'b1, c)
    `CHK("mem", 8'h81, rd)
    run(OP_ROT, 8'h01);
    `CHK("acc", 8'h80, acc)
  endtask
  task t_sub;
    run(OP_SUB_ACC, 8'h81);
    `CHK("acc", 8'hff, acc)
    `CHK("carry", 1'b0, c)
    `CHK("zero", 1'b0, z)
    `CHK("ovf", 1'b0, ov)
    `CHK("aux", 1'b0, ac)
    run(OP_SUB_MEM, 8'h10);
    `CHK("mem", 8'hee, rd)
    `CHK("carry", 1'b1, c)
    `CHK("aux", 1'b1, ac)
    `CHK("acc", 8'hff, acc)
  endtask
  task t_flags;
    run(OP_SUB_ACC, 8'hff);
    `CHK("acc", 8'h00, acc)
    `CHK("zero", 1'b1, z)
    `CHK("carry", 1'b1, c)
    run(OP_SUB_ACC, 8'h80);
    `CHK("acc", 8'h80, acc)
    `CHK("ovf", 1'b1, ov)
    `CHK("zero", 1'b0, z)
    `CHK("carry", 1'b0, c)
  endtask
  task t_dec;
    run(OP_DEC_SKIP, 8'h01);
    `CHK("mem", 8'h00, rd)
    `CHK("skip", 1'b1, skd)
    `CHK("carry", 1'b1, c)
    `CHK("aux", 1'b1, ac)
    `CHK("zero", 1'b0, z)
    `CHK("done", 1'b1, dnd)
    `CHK("done low", 1'b0, done)
    run(OP_DEC_SKIP, 8'h00);
    `CHK("mem", 8'hff, rd)
    `CHK("skip", 1'b0, skd)
  endtask
  task summarize;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_rot;
    t_sub;
    t_dec;
    t_flags;
    summarize;
  end
  // some 45 cycles of work; far more means a hang
  initial
  begin
    #2000;
    fail_count++;
    summarize;
  end
endmodule
`default_nettype wire
